// [verilog/monitor_config_status_regs.v]
// Notes on behaviour
// RULE1: Poll rate 1, 2, 5, 10 per second
// RULE2: Retry-off bit clears retry flag
// RULE3: Detection bit shows processor found
// RULE4: Thermal-interface writes only when allowed
// RULE5: Domain-count bit: single or multiple
// RULE6: Per-fan max duty caps, reset full
// RULE7: Above minimum temp, ramp from min duty
// RULE8: Four-bit span field, reset 32 degrees
// RULE9: Critical limit forces full; 0x80 disables
// RULE10: Version register read-only, fixed fields
// RULE11: Stopped means full duty, limits kept
// RULE12: Lock write-once, holds until power cycle
// RULE13: Run and boost still writable locked
// RULE14: Ready bit set after power-up
// RULE15: Boost forces all fans full
// RULE16: CPU monitoring only when enabled
// RULE17: Overtemp pin forces full or max
// RULE18: Analog averaging 4, 8, 16, 32
// RULE19: Latched status clears on read if gone
// RULE20: Summary bits OR the next registers
// RULE21: Stall flags gated by output activity
// RULE22: Diode fault status bits
// RULE23: CPU averaging 1, 2, 4, 8 samples
// RULE24: Reserved bits read zero, ignore writes
`include "monitor_regs_defs.vh"
module monitor_config_status_regs (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Thermal interface side
  input wire cpu_found_in,
  input wire [7:0] cpu_temp,
  input wire cpu_temp_valid,
  input wire cpu_bad_completion,
  input wire cpu_write_req,
  output reg cpu_poll_tick,
  output reg cpu_monitor_on,
  output reg cpu_retry_flag,
  output reg cpu_write_grant,
  output reg domain_count_sel,
  output reg [2:0] cpu_sample_avg,
  // Analog measurement side
  output reg [1:0] analog_avg_len,
  // Status conditions
  input wire [7:0] limit_cond_first,
  input wire volt12_cond,
  input wire [2:0] fan_stall_cond,
  input wire fan_four_stall_cond,
  input wire tach4_enabled,
  input wire diode_one_fault,
  input wire diode_two_fault,
  input wire third_status_any,
  // Fan side
  input wire overtemp_pin,
  input wire [2:0] overtemp_full_sel,
  input wire [2:0] min_duty_en,
  input wire [7:0] min_duty,
  input wire [23:0] fan_duty_calc,
  output reg [23:0] fan_duty,
  output reg [3:0] span_code,
  output reg crit_active
);
  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  reg [7:0] cpu_iface_config_a_reg;
  reg [7:0] cpu_iface_config_b_reg;
  reg [7:0] fan_one_stall_max_duty_reg;
  reg [7:0] fan2_max_duty_reg;
  reg [7:0] fan3_max_duty_reg;
  reg [7:0] cpu_min_temp_reg;
  reg [7:0] cpu_temp_span_reg;
  reg [7:0] cpu_critical_limit_reg;
  reg [7:0] main_config_reg;
  reg ready_reg;
  reg [4:0] ready_cnt_reg;
  reg ovt_s1_reg;
  reg ovt_s2_reg;
  reg cpu_found_s1_reg;
  reg cpu_found_s2_reg;
  reg [7:0] cpu_temp_reg;
  wire locked;
  wire monitor_run;
  wire [7:0] stat1_flags;
  wire [7:0] stat2_flags;
  wire [7:0] stat2_cond;
  wire [7:0] stat1_cond;
  wire rd_stat1;
  wire rd_stat2;
  wire poll_tick;
  wire [7:0] version_val;

  assign locked = main_config_reg[`B_LOCK];
  assign monitor_run = main_config_reg[`B_RUN];
  assign rd_stat1 = reg_rd && (reg_addr == `OFS_STAT1);
  assign rd_stat2 = reg_rd && (reg_addr == `OFS_STAT2);
  assign version_val = {`FAMILY_VER_VAL, 1'b1, 1'b1,
                        `SILICON_REV_VAL}; // [RULE10]

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovt_s1_reg <= 1'b0;
      ovt_s2_reg <= 1'b0;
      cpu_found_s1_reg <= 1'b0;
      cpu_found_s2_reg <= 1'b0;
    end else begin
      ovt_s1_reg <= overtemp_pin;
      ovt_s2_reg <= ovt_s1_reg;
      cpu_found_s1_reg <= cpu_found_in;
      cpu_found_s2_reg <= cpu_found_s1_reg;
    end
  end

  // --------------------------------------------------------------
  // Power-up ready
  // --------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ready_cnt_reg <= 5'h00;
      ready_reg <= 1'b0;
    end else if (ready_cnt_reg == `READY_DELAY_CYC) begin
      ready_reg <= 1'b1; // [RULE14]
    end else begin
      ready_cnt_reg <= ready_cnt_reg + 5'h01;
    end
  end

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_iface_config_a_reg <= `RST_CPU_CFG_A;
      cpu_iface_config_b_reg <= `RST_CPU_CFG_B;
      fan_one_stall_max_duty_reg <= `RST_FAN_MAX; // [RULE6]
      fan2_max_duty_reg <= `RST_FAN_MAX;
      fan3_max_duty_reg <= `RST_FAN_MAX;
      cpu_min_temp_reg <= `RST_CPU_MIN;
      cpu_temp_span_reg <= `RST_CPU_SPAN; // [RULE8]
      cpu_critical_limit_reg <= `RST_CPU_CRIT;
      main_config_reg <= `RST_MAIN_CFG & 8'hFB;
    end else begin
      // Detection bit follows the interface logic
      cpu_iface_config_b_reg[`B_FOUND] <= cpu_found_s2_reg; // [RULE3]
      if (reg_wr && !locked) begin // [RULE12]
        case (reg_addr)
          `OFS_CPU_CFG_A:
            cpu_iface_config_a_reg <= reg_wdata &
                                      `MASK_CPU_CFG_A; // [RULE24]
          `OFS_CPU_CFG_B:
            cpu_iface_config_b_reg <= (reg_wdata & 8'hB2) |
                                      {7'h00, cpu_found_s2_reg};
          `OFS_FAN_ONE_STALL_MAX: fan_one_stall_max_duty_reg <= reg_wdata;
          `OFS_FAN2_MAX: fan2_max_duty_reg <= reg_wdata;
          `OFS_FAN3_MAX: fan3_max_duty_reg <= reg_wdata;
          `OFS_CPU_MIN: cpu_min_temp_reg <= reg_wdata;
          `OFS_CPU_SPAN:
            cpu_temp_span_reg <= reg_wdata & `MASK_CPU_SPAN; // [RULE24]
          `OFS_CPU_CRIT: cpu_critical_limit_reg <= reg_wdata;
          `OFS_MAIN_CFG: begin
            main_config_reg[`B_RUN] <= reg_wdata[`B_RUN];
            main_config_reg[`B_LOCK] <= reg_wdata[`B_LOCK]; // [RULE12]
            main_config_reg[`B_BOOST] <= reg_wdata[`B_BOOST];
            main_config_reg[`B_MON] <= reg_wdata[`B_MON];
            main_config_reg[`B_OVR] <= reg_wdata[`B_OVR];
            main_config_reg[7:6] <= reg_wdata[7:6]; // [RULE18]
          end
          default: ;
        endcase
      end else if (reg_wr && (reg_addr == `OFS_MAIN_CFG)) begin
        main_config_reg[`B_RUN] <= reg_wdata[`B_RUN]; // [RULE13]
        main_config_reg[`B_BOOST] <= reg_wdata[`B_BOOST]; // [RULE13]
      end
    end
  end

  // --------------------------------------------------------------
  // Status registers
  // --------------------------------------------------------------
  assign stat1_cond = {stat2_flags != 8'h00, limit_cond_first[6:0]};
  assign stat2_cond[0] = volt12_cond;
  assign stat2_cond[1] = third_status_any; // [RULE20]
  assign stat2_cond[4:2] = fan_stall_cond &
                           {fan_duty[23:16] != 8'h00,
                            fan_duty[15:8] != 8'h00,
                            fan_duty[7:0] != 8'h00}; // [RULE21]
  assign stat2_cond[5] = fan_four_stall_cond & tach4_enabled &
                         (fan_duty[23:16] != 8'h00); // [RULE21]
  assign stat2_cond[6] = diode_one_fault; // [RULE22]
  assign stat2_cond[7] = diode_two_fault; // [RULE22]

  sticky_status u_stat1 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cond(stat1_cond),
    .read_clr(rd_stat1),
    .flags(stat1_flags)
  ); // [RULE19]

  sticky_status u_stat2 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cond(stat2_cond),
    .read_clr(rd_stat2),
    .flags(stat2_flags)
  ); // [RULE19]

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_CPU_CFG_A: reg_rdata <= cpu_iface_config_a_reg;
        `OFS_CPU_CFG_B: reg_rdata <= cpu_iface_config_b_reg;
        `OFS_FAN_ONE_STALL_MAX: reg_rdata <= fan_one_stall_max_duty_reg;
        `OFS_FAN2_MAX: reg_rdata <= fan2_max_duty_reg;
        `OFS_FAN3_MAX: reg_rdata <= fan3_max_duty_reg;
        `OFS_CPU_MIN: reg_rdata <= cpu_min_temp_reg;
        `OFS_CPU_SPAN: reg_rdata <= cpu_temp_span_reg;
        `OFS_CPU_CRIT: reg_rdata <= cpu_critical_limit_reg;
        `OFS_MAKER: reg_rdata <= `MAKER_CODE_VAL;
        `OFS_VERSION: reg_rdata <= version_val; // [RULE10]
        `OFS_MAIN_CFG:
          reg_rdata <= {main_config_reg[7:3], ready_reg,
                        main_config_reg[1:0]}; // [RULE14]
        `OFS_STAT1: reg_rdata <= stat1_flags;
        `OFS_STAT2: reg_rdata <= stat2_flags;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Thermal interface control
  // --------------------------------------------------------------
  poll_timer u_poll (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(main_config_reg[`B_MON]),
    .rate_sel(cpu_iface_config_b_reg[5:4]),
    .tick(poll_tick)
  ); // [RULE1]

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_poll_tick <= 1'b0;
      cpu_monitor_on <= 1'b0;
      cpu_retry_flag <= 1'b1;
      cpu_write_grant <= 1'b0;
      domain_count_sel <= 1'b0;
      cpu_sample_avg <= 3'h0;
      analog_avg_len <= 2'h2;
      span_code <= 4'hC;
      cpu_temp_reg <= 8'h00;
    end else begin
      cpu_monitor_on <= main_config_reg[`B_MON]; // [RULE16]
      cpu_poll_tick <= poll_tick & main_config_reg[`B_MON]; // [RULE16]
      if (cpu_bad_completion)
        cpu_retry_flag <= ~cpu_iface_config_b_reg[`B_RETRY_OFF]; // [RULE2]
      else if (!cpu_iface_config_b_reg[`B_RETRY_OFF])
        cpu_retry_flag <= 1'b1; // [RULE2]
      cpu_write_grant <= cpu_write_req &
                         cpu_iface_config_b_reg[`B_WRITE_ALLOW]; // [RULE4]
      domain_count_sel <= cpu_iface_config_a_reg[`B_DOMAIN]; // [RULE5]
      cpu_sample_avg <= cpu_iface_config_a_reg[2] ?
                        3'h0 : cpu_iface_config_a_reg[2:0]; // [RULE23]
      analog_avg_len <= main_config_reg[7:6]; // [RULE18]
      span_code <= cpu_temp_span_reg[7:4]; // [RULE8]
      if (cpu_temp_valid && main_config_reg[`B_MON])
        cpu_temp_reg <= cpu_temp;
    end
  end

  // --------------------------------------------------------------
  // Critical limit with hysteresis
  // --------------------------------------------------------------
  localparam [7:0] CRIT_HYST = 8'h04;
  wire crit_on;
  assign crit_on = (cpu_critical_limit_reg != `CRIT_DISABLE) &&
                   ($signed(cpu_temp_reg) >
                    $signed(cpu_critical_limit_reg));
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      crit_active <= 1'b0;
    else if (cpu_critical_limit_reg == `CRIT_DISABLE)
      crit_active <= 1'b0; // [RULE9]
    else if (crit_on)
      crit_active <= 1'b1; // [RULE9]
    else if ($signed(cpu_temp_reg) <
             $signed(cpu_critical_limit_reg - CRIT_HYST))
      crit_active <= 1'b0; // [RULE9]
  end

  // --------------------------------------------------------------
  // Duty selection per fan
  // --------------------------------------------------------------
  wire [23:0] max_all;
  wire above_min;
  assign max_all = {fan3_max_duty_reg, fan2_max_duty_reg,
                    fan_one_stall_max_duty_reg};
  assign above_min = $signed(cpu_temp_reg) >
                     $signed(cpu_min_temp_reg); // [RULE7]

  genvar f;
  generate
    for (f = 0; f < 3; f = f + 1) begin : g_fan
      reg [7:0] duty_next;
      reg [7:0] calc;
      always @* begin
        calc = fan_duty_calc[f*8 +: 8];
        if (above_min && calc < min_duty)
          calc = min_duty; // [RULE7]
        else if (!above_min)
          calc = min_duty_en[f] ? min_duty : 8'h00;
        if (calc > max_all[f*8 +: 8])
          calc = max_all[f*8 +: 8]; // [RULE6]
        duty_next = calc;
        if (!monitor_run)
          duty_next = `FULL_DUTY; // [RULE11]
        if (crit_active)
          duty_next = `FULL_DUTY; // [RULE9]
        if (main_config_reg[`B_OVR] && ovt_s2_reg)
          duty_next = overtemp_full_sel[f] ?
                      `FULL_DUTY : max_all[f*8 +: 8]; // [RULE17]
        if (main_config_reg[`B_BOOST])
          duty_next = `FULL_DUTY; // [RULE15]
      end
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
          fan_duty[f*8 +: 8] <= `FULL_DUTY;
        else
          fan_duty[f*8 +: 8] <= duty_next;
      end
    end
  endgenerate
endmodule // monitor_config_status_regs

// [common/monitor_regs_defs.vh]
`ifndef MONITOR_REGS_DEFS_VH
`define MONITOR_REGS_DEFS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CPU_CFG_A 8'h36
`define OFS_CPU_CFG_B 8'h37
`define OFS_FAN_ONE_STALL_MAX 8'h38
`define OFS_FAN2_MAX 8'h39
`define OFS_FAN3_MAX 8'h3A
`define OFS_CPU_MIN 8'h3B
`define OFS_CPU_SPAN 8'h3C
`define OFS_CPU_CRIT 8'h3D
`define OFS_MAKER 8'h3E
`define OFS_VERSION 8'h3F
`define OFS_MAIN_CFG 8'h40
`define OFS_STAT1 8'h41
`define OFS_STAT2 8'h42
// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define RST_CPU_CFG_A 8'h00
`define RST_CPU_CFG_B 8'h32
`define RST_FAN_MAX 8'hFF
`define RST_CPU_MIN 8'hD6
`define RST_CPU_SPAN 8'hC0
`define RST_CPU_CRIT 8'h00
`define RST_MAIN_CFG 8'h84
`define MASK_CPU_CFG_A 8'h0F
`define MASK_CPU_CFG_B 8'hB3
`define MASK_CPU_SPAN 8'hF0
`define CRIT_DISABLE 8'h80
`define CPU_MIN_ABS_MAX 8'hAF
`define FULL_DUTY 8'hFF
// Arbitrary identity values
`define MAKER_CODE_VAL 8'h5A
`define FAMILY_VER_VAL 4'h3
`define SILICON_REV_VAL 2'h0
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define B_FOUND 0
`define B_RETRY_OFF 1
`define B_WRITE_ALLOW 7
`define B_DOMAIN 3
`define B_RUN 0
`define B_LOCK 1
`define B_READY 2
`define B_BOOST 3
`define B_MON 4
`define B_OVR 5
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 50000000
`define READY_DELAY_CYC 16
`endif

// [verilog/poll_timer.v]
`include "monitor_regs_defs.vh"
module poll_timer (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Control
  input wire enable,
  input wire [1:0] rate_sel,
  // Tick
  output reg tick
);
  reg [25:0] cnt_reg;
  reg [25:0] limit;

  // ------------------------------------------------------------
  // Update period per code
  // ------------------------------------------------------------
  always @* begin
    case (rate_sel)
      2'b00: limit = 26'd49999999;
      2'b01: limit = 26'd24999999;
      2'b10: limit = 26'd9999999;
      default: limit = 26'd4999999;
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 26'h0000000;
      tick <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= 26'h0000000;
      tick <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= 26'h0000000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 26'h0000001;
      tick <= 1'b0;
    end
  end
endmodule // poll_timer

// [verilog/sticky_status.v]
module sticky_status (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Events and clear
  input wire [7:0] cond,
  input wire read_clr,
  // Status
  output reg [7:0] flags
);
  // ------------------------------------------------------------
  // One latch per bit
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
          flags[i] <= 1'b0;
        else if (cond[i])
          flags[i] <= 1'b1;
        else if (read_clr)
          flags[i] <= 1'b0;
      end
    end
  endgenerate
endmodule // sticky_status

// [sim/monitor_regs_chk.sv]
module monitor_regs_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // Thermal interface
  input wire logic cpu_bad_completion,
  input wire logic cpu_write_req,
  input wire logic cpu_poll_tick,
  input wire logic cpu_monitor_on,
  input wire logic cpu_retry_flag,
  input wire logic cpu_write_grant,
  input wire logic domain_count_sel,
  input wire logic [2:0] cpu_sample_avg,
  input wire logic [1:0] analog_avg_len,
  // Fan side
  input wire logic [2:0] overtemp_full_sel,
  input wire logic [23:0] fan_duty,
  input wire logic [3:0] span_code,
  input wire logic crit_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_36;
  logic wr_3c;
  logic wr_40;
  assign wr_36 = reg_wr && reg_addr == 8'h36;
  assign wr_3c = reg_wr && reg_addr == 8'h3C;
  assign wr_40 = reg_wr && reg_addr == 8'h40;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  sequence ver_read;
    reg_rd && reg_addr == 8'h3F;
  endsequence
  sequence hole_read;
    reg_rd && (reg_addr < 8'h36 || reg_addr > 8'h42);
  endsequence
  sequence crit_held;
    crit_active [*2] ##0 overtemp_full_sel == 3'b111;
  endsequence
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  version_fixed_a: assert property (ver_read |=> reg_rdata == 8'h3C)
    else $error("version read wrong");
  hole_zero_a: assert property (hole_read |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(reg_rdata) |-> $past(reg_rd))
    else $error("read data moved without read");
  grant_cause_a: assert property (cpu_write_grant |-> $past(cpu_write_req))
    else $error("write grant without request");
  retry_clear_a: assert property ($fell(cpu_retry_flag) |-> $past(cpu_bad_completion))
    else $error("retry flag dropped without bad completion");
  poll_gate_a: assert property (!cpu_monitor_on && !$past(cpu_monitor_on) |-> !cpu_poll_tick)
    else $error("poll tick while monitor off");
  crit_full_a: assert property (crit_held |-> fan_duty == 24'hFFFFFF)
    else $error("critical state without full duty");
  domain_src_a: assert property ($changed(domain_count_sel) |-> $past(wr_36) || $past(wr_36, 2))
    else $error("domain select changed without write");
  span_src_a: assert property ($changed(span_code) |-> $past(wr_3c) || $past(wr_3c, 2))
    else $error("span code changed without write");
  avg_len_src_a: assert property ($changed(analog_avg_len) |-> $past(wr_40) || $past(wr_40, 2))
    else $error("averaging length changed without write");
  cpu_avg_code_a: assert property (cpu_sample_avg[2] == 1'b0)
    else $error("reserved averaging code driven");
endmodule // monitor_regs_chk

bind monitor_config_status_regs monitor_regs_chk monitor_regs_chk_inst (
  .clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .cpu_bad_completion(cpu_bad_completion), .cpu_write_req(cpu_write_req),
  .cpu_poll_tick(cpu_poll_tick), .cpu_monitor_on(cpu_monitor_on),
  .cpu_retry_flag(cpu_retry_flag), .cpu_write_grant(cpu_write_grant),
  .domain_count_sel(domain_count_sel), .cpu_sample_avg(cpu_sample_avg),
  .analog_avg_len(analog_avg_len), .overtemp_full_sel(overtemp_full_sel),
  .fan_duty(fan_duty), .span_code(span_code), .crit_active(crit_active));

// [sim/reg_host.sv]
module reg_host (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Idle lines carry inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
endmodule // reg_host

// [sim/test_monitor_config_status_regs.sv]
`include "monitor_regs_defs.vh"
module test_monitor_config_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, reg_wr, reg_rd, cpu_found_in, cpu_temp_valid;
  logic cpu_bad_completion, cpu_write_req, volt12_cond, fan_four_stall_cond;
  logic tach4_enabled, diode_one_fault, diode_two_fault, third_status_any;
  logic overtemp_pin, cpu_poll_tick, cpu_monitor_on, cpu_retry_flag;
  logic cpu_write_grant, domain_count_sel, crit_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cpu_temp, limit_cond_first;
  logic [7:0] min_duty, ra, rv;
  logic [2:0] cpu_sample_avg, fan_stall_cond, overtemp_full_sel, min_duty_en;
  logic [1:0] analog_avg_len;
  logic [3:0] span_code;
  logic [23:0] fan_duty_calc, fan_duty;
  logic [7:0] rnd_addr [5] = '{8'h38, 8'h39, 8'h3A, 8'h3C, 8'h3D};
  int error_cnt = 0;
  int num_checks = 0;
  // --------------------------------------------------------------
  // Design and host
  // --------------------------------------------------------------
  monitor_config_status_regs monitor_config_status_regs_inst (
    .clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .cpu_found_in, .cpu_temp, .cpu_temp_valid, .cpu_bad_completion,
    .cpu_write_req, .cpu_poll_tick, .cpu_monitor_on, .cpu_retry_flag,
    .cpu_write_grant, .domain_count_sel, .cpu_sample_avg, .analog_avg_len,
    .limit_cond_first, .volt12_cond, .fan_stall_cond, .fan_four_stall_cond,
    .tach4_enabled, .diode_one_fault, .diode_two_fault, .third_status_any,
    .overtemp_pin, .overtemp_full_sel, .min_duty_en, .min_duty,
    .fan_duty_calc, .fan_duty, .span_code, .crit_active);
  reg_host reg_host_inst (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h37: rst_val = 8'h32;
      8'h38, 8'h39, 8'h3A: rst_val = 8'hFF;
      8'h3B: rst_val = 8'hD6;
      8'h3C: rst_val = 8'hC0;
      8'h3E: rst_val = `MAKER_CODE_VAL;
      8'h3F: rst_val = {`FAMILY_VER_VAL, 2'b11, `SILICON_REV_VAL};
      8'h40: rst_val = 8'h84;
      default: rst_val = 8'h00;
    endcase
  endfunction
  // Caps set below: fan two at 50, fan one at 60
  function automatic logic [23:0] duty(input logic [23:0] c);
    duty = {c[23:16], (c[15:8] > 8'h50) ? 8'h50 : c[15:8],
      (c[7:0] > 8'h60) ? 8'h60 : c[7:0]};
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    reg_host_inst.wr(a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_host_inst.rd(a, d);
    chk(24'(d), 24'(e));
  endtask
  task automatic tmp(input logic [7:0] t);
    cpu_temp <= t;
    cpu_temp_valid <= 1'b1;
    cyc(1);
    cpu_temp_valid <= 1'b0;
    cyc(4);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    close_out;
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {resetn, cpu_found_in, cpu_temp, cpu_temp_valid, cpu_bad_completion,
      cpu_write_req, limit_cond_first, volt12_cond, fan_stall_cond,
      fan_four_stall_cond, tach4_enabled, diode_one_fault, diode_two_fault,
      third_status_any, overtemp_pin, overtemp_full_sel, min_duty_en,
      min_duty, fan_duty_calc} = '0;
    void'($urandom(32'h0EFC));
    cyc(10);
    resetn <= 1'b1;
    cyc(25);
    for (int a = 8'h36; a <= 8'h43; a++) rc(a[7:0], rst_val(a[7:0]));
    rc(8'hA5, 8'h00);
    cpu_found_in <= 1'b1;
    cyc(4);
    rc(8'h37, 8'h33);
    w(8'h36, 8'hFF);
    rc(8'h36, 8'h0F);
    chk(24'({domain_count_sel, cpu_sample_avg}), 24'h8);
    w(8'h36, 8'h03);
    cyc(2);
    chk(24'(cpu_sample_avg), 24'h3);
    w(8'h3C, 8'hFF);
    rc(8'h3C, 8'hF0);
    chk(24'(span_code), 24'hF);
    w(8'h3F, 8'h00);
    rc(8'h3F, rst_val(8'h3F));
    for (int i = 0; i < 10; i++) begin
      ra = rnd_addr[i % 5];
      rv = 8'($urandom);
      w(ra, rv);
      rc(ra, (ra == 8'h3C) ? (rv & 8'hF0) : rv);
    end
    w(8'h38, 8'h60);
    w(8'h39, 8'h50);
    w(8'h3A, 8'hFF);
    w(8'h3C, 8'hC0);
    w(8'h3D, 8'h80);
    w(8'h37, 8'h82);
    rc(8'h37, 8'h83);
    cpu_write_req <= 1'b1;
    cyc(3);
    chk(24'(cpu_write_grant), 24'h1);
    cpu_bad_completion <= 1'b1;
    cyc(1);
    cpu_bad_completion <= 1'b0;
    cyc(2);
    chk(24'(cpu_retry_flag), 24'h0);
    w(8'h37, 8'h00);
    cyc(3);
    chk(24'({cpu_write_grant, cpu_retry_flag}), 24'h1);
    cpu_write_req <= 1'b0;
    fan_duty_calc <= 24'h909090;
    w(8'h40, 8'hC1);
    cyc(3);
    chk(24'(analog_avg_len), 24'h3);
    chk(fan_duty, duty(24'h909090));
    w(8'h40, 8'hC9);
    cyc(3);
    chk(fan_duty, 24'hFFFFFF);
    w(8'h40, 8'hC1);
    cyc(3);
    chk(fan_duty, duty(24'h909090));
    w(8'h40, 8'hC0);
    cyc(3);
    chk(fan_duty, 24'hFFFFFF);
    overtemp_full_sel <= 3'b001;
    w(8'h40, 8'hE1);
    overtemp_pin <= 1'b1;
    cyc(5);
    chk(fan_duty, 24'hFF50FF);
    overtemp_pin <= 1'b0;
    cyc(5);
    chk(fan_duty, duty(24'h909090));
    overtemp_full_sel <= 3'b111;
    w(8'h3D, 8'h40);
    w(8'h40, 8'hC1);
    tmp(8'h50);
    chk(24'(crit_active), 24'h0);
    w(8'h40, 8'hD1);
    cyc(2);
    chk(24'(cpu_monitor_on), 24'h1);
    tmp(8'h50);
    chk(fan_duty, 24'hFFFFFF);
    tmp(8'h3E);
    chk(24'(crit_active), 24'h1);
    tmp(8'h30);
    chk(24'(crit_active), 24'h0);
    chk(fan_duty, duty(24'h909090));
    w(8'h3D, 8'h80);
    tmp(8'h7F);
    chk(24'(crit_active), 24'h0);
    limit_cond_first <= 8'h03;
    cyc(1);
    limit_cond_first <= 8'h02;
    cyc(2);
    rc(8'h41, 8'h03);
    limit_cond_first <= 8'h00;
    rc(8'h41, 8'h02);
    rc(8'h41, 8'h00);
    {volt12_cond, diode_one_fault, diode_two_fault} <= 3'b111;
    {fan_stall_cond, fan_four_stall_cond, tach4_enabled} <= 5'b00111;
    third_status_any <= 1'b1;
    cyc(1);
    {volt12_cond, diode_one_fault, diode_two_fault} <= 3'b000;
    {fan_stall_cond, fan_four_stall_cond, tach4_enabled} <= 5'b0;
    cyc(2);
    rc(8'h41, 8'h80);
    rc(8'h42, 8'hE7);
    rc(8'h42, 8'h02);
    rc(8'h41, 8'h80);
    third_status_any <= 1'b0;
    cyc(2);
    reg_host_inst.rd(8'h42, ra);
    fan_duty_calc <= 24'h000000;
    cyc(4);
    {fan_stall_cond, fan_four_stall_cond, tach4_enabled} <= 5'b11111;
    cyc(1);
    {fan_stall_cond, fan_four_stall_cond, tach4_enabled} <= 5'b0;
    cyc(2);
    rc(8'h42, 8'h00);
    min_duty <= 8'h20;
    cyc(3);
    chk(fan_duty, 24'h202020);
    fan_duty_calc <= 24'h909090;
    w(8'h40, 8'hD3);
    rc(8'h40, 8'hD7);
    w(8'h38, 8'h11);
    rc(8'h38, 8'h60);
    w(8'h40, 8'h08);
    rc(8'h40, 8'hDE);
    chk(fan_duty, 24'hFFFFFF);
    w(8'h40, 8'h01);
    rc(8'h40, 8'hD7);
    chk(fan_duty, duty(24'h909090));
    close_out;
  end
endmodule // test_monitor_config_status_regs
